// File: hdl/dofc_top.sv
`timescale 1ns/1ps
`include "dofc_map.svh"

// Summary of operation
// - Bits 6 and 5 pick each output's family.
// - Bits 7:6 pick second output spot frequency.
// - Bits 5:4 pick first output spot frequency.
// - Bits 1:0 set differential driver mode.

module dofc_top (
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    input  wire logic                     clk_en,
    input  wire logic [11:0]              s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [11:0]              s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    output logic                          first_output_family_sel,
    output logic                          second_output_family_sel,
    output logic [1:0]                    first_output_freq_code,
    output logic [1:0]                    second_output_freq_code,
    output logic [14:0]                   first_aux_clock_out_khz,
    output logic [14:0]                   second_aux_clock_out_khz,
    output dofc_pkg::dofc_diff_mode_t     diff_driver_mode
);

    // =================================================================
    // Decoding helpers
    // =================================================================

    // A set family bit selects the SONET member of each frequency pair.
    function automatic logic [14:0] spot_khz(input logic sonet,
                                             input logic [1:0] code);
        logic [14:0] khz;
        khz = 15'h0000;
        unique case (code)
            2'h0: khz = sonet ? `DOFC_KHZ_SONET_0 : `DOFC_KHZ_SDH_0;
            2'h1: khz = sonet ? `DOFC_KHZ_SONET_1 : `DOFC_KHZ_SDH_1;
            2'h2: khz = sonet ? `DOFC_KHZ_SONET_2 : `DOFC_KHZ_SDH_2;
            2'h3: khz = sonet ? `DOFC_KHZ_SONET_3 : `DOFC_KHZ_SDH_3;
        endcase
        return khz;
    endfunction

    // Code 11 has no defined driver standard, so it keeps the driver off
    // rather than guessing at an electrical level.
    function automatic dofc_pkg::dofc_diff_mode_t diff_decode(input logic [1:0] code);
        dofc_pkg::dofc_diff_mode_t mode;
        mode = dofc_pkg::DOFC_DIFF_OFF;
        unique case (code)
            2'h0: mode = dofc_pkg::DOFC_DIFF_OFF;
            2'h1: mode = dofc_pkg::DOFC_DIFF_PECL;
            2'h2: mode = dofc_pkg::DOFC_DIFF_LVDS;
            2'h3: mode = dofc_pkg::DOFC_DIFF_OFF;
        endcase
        return mode;
    endfunction

    // Only writable bits take new data; the rest keep their reset value.
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] data,
                                         input logic [7:0] wmask);
        return (old & ~wmask) | (data & wmask);
    endfunction

    function automatic logic [9:0] word_index(input logic [11:0] addr);
        return addr[11:2];
    endfunction

    // One-hot register select: bit 0 family, bit 1 frequency, bit 2 driver
    // mode.  Writes and reads share it, so the two decoders cannot drift.
    function automatic logic [2:0] reg_select(input logic [9:0] idx);
        logic [2:0] sel;
        sel = 3'h0;
        unique case (idx)
            `DOFC_IDX_FAMILY: sel = 3'h1;
            `DOFC_IDX_FREQ:   sel = 3'h2;
            `DOFC_IDX_DIFF:   sel = 3'h4;
            default:          sel = 3'h0;
        endcase
        return sel;
    endfunction

    function automatic logic is_mapped(input logic [9:0] idx);
        return |reg_select(idx);
    endfunction

    // =================================================================
    // State and reset value
    // =================================================================

    // Sized copies of the reset bytes, so that single fields can be picked
    // out; a bare literal cannot be indexed.
    localparam logic [7:0] RST_FAMILY      = `DOFC_RST_FAMILY;
    localparam logic [7:0] RST_FREQ        = `DOFC_RST_FREQ;
    localparam logic [7:0] RST_DIFF        = `DOFC_RST_DIFF;
    localparam logic       RST_FIRST_FAM   = RST_FAMILY[`DOFC_FIRST_FAM_BIT];
    localparam logic       RST_SECOND_FAM  = RST_FAMILY[`DOFC_SECOND_FAM_BIT];
    localparam logic [1:0] RST_FIRST_CODE  = RST_FREQ[`DOFC_FIRST_CODE_LO +: 2];
    localparam logic [1:0] RST_SECOND_CODE = RST_FREQ[`DOFC_SECOND_CODE_LO +: 2];
    localparam logic [1:0] RST_DIFF_CODE   = RST_DIFF[`DOFC_DIFF_LO +: 2];

    localparam dofc_pkg::dofc_state_t RST_STATE = '{
        awready     : 1'b1,
        wready      : 1'b1,
        bvalid      : 1'b0,
        bresp       : `DOFC_RESP_OKAY,
        arready     : 1'b1,
        rvalid      : 1'b0,
        rresp       : `DOFC_RESP_OKAY,
        rdata       : 32'h0000_0000,
        aw_got      : 1'b0,
        w_got       : 1'b0,
        awaddr      : 12'h000,
        wdata       : 8'h00,
        wlane0      : 1'b0,
        family      : RST_FAMILY,
        freq        : RST_FREQ,
        diff        : RST_DIFF,
        first_fam   : RST_FIRST_FAM,
        second_fam  : RST_SECOND_FAM,
        first_code  : RST_FIRST_CODE,
        second_code : RST_SECOND_CODE,
        first_khz   : spot_khz(RST_FIRST_FAM, RST_FIRST_CODE),
        second_khz  : spot_khz(RST_SECOND_FAM, RST_SECOND_CODE),
        diff_mode   : diff_decode(RST_DIFF_CODE)
    };

    dofc_pkg::dofc_state_t state_reg;
    dofc_pkg::dofc_state_t state_next;

    // =================================================================
    // Next-state logic
    // =================================================================

    // One write and one read may be in flight at once, independent of each
    // other.  A write is answered one cycle after the later of its address
    // and data is taken, a read one cycle after its address.  The low two
    // address bits, the protection fields and byte lanes 1 to 3 are ignored,
    // so a narrow or unaligned access still lands on the whole word.  An
    // index outside the map answers with a slave error and changes nothing;
    // a read of it returns zero.
    always_comb begin
        logic [9:0] widx;
        logic [9:0] ridx;
        logic [2:0] wsel;
        logic [2:0] rsel;
        state_next = state_reg;
        widx       = 10'h000;
        ridx       = word_index(s_axi_araddr);
        wsel       = 3'h0;
        rsel       = reg_select(ridx);

        // Address and data are captured independently, in either order.
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.awaddr  = s_axi_awaddr;
            state_next.aw_got  = 1'b1;
            state_next.awready = 1'b0;
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.wdata  = s_axi_wdata[7:0];
            state_next.wlane0 = s_axi_wstrb[0];
            state_next.w_got  = 1'b1;
            state_next.wready = 1'b0;
        end

        // Both halves present: commit and answer.  Only byte lane 0 holds
        // register data, so a write without it changes nothing.
        if (state_next.aw_got && state_next.w_got && !state_reg.bvalid) begin
            widx              = word_index(state_next.awaddr);
            wsel              = reg_select(widx);
            state_next.aw_got = 1'b0;
            state_next.w_got  = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp  = is_mapped(widx) ? `DOFC_RESP_OKAY
                                                : `DOFC_RESP_SLVERR;
            if (state_next.wlane0) begin
                if (wsel[0]) begin
                    state_next.family = merge(state_reg.family, state_next.wdata,
                                              `DOFC_WMASK_FAMILY);
                end
                if (wsel[1]) begin
                    state_next.freq = merge(state_reg.freq, state_next.wdata,
                                            `DOFC_WMASK_FREQ);
                end
                if (wsel[2]) begin
                    state_next.diff = merge(state_reg.diff, state_next.wdata,
                                            `DOFC_WMASK_DIFF);
                end
            end
        end

        // New address and data are only accepted once the response is gone,
        // which keeps a single write in flight.
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid  = 1'b0;
            state_next.awready = 1'b1;
            state_next.wready  = 1'b1;
        end

        // Reads return the whole stored byte; fixed bits hold their default.
        if (s_axi_arvalid && state_reg.arready) begin
            state_next.arready = 1'b0;
            state_next.rvalid  = 1'b1;
            state_next.rresp   = is_mapped(ridx) ? `DOFC_RESP_OKAY
                                                 : `DOFC_RESP_SLVERR;
            state_next.rdata   = 32'h0000_0000;
            if (rsel[0]) begin
                state_next.rdata[7:0] = state_reg.family;
            end
            if (rsel[1]) begin
                state_next.rdata[7:0] = state_reg.freq;
            end
            if (rsel[2]) begin
                state_next.rdata[7:0] = state_reg.diff;
            end
        end
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid  = 1'b0;
            state_next.arready = 1'b1;
        end

        // Decoded settings are computed from the next register value, so
        // they change at the same edge as the register and every output
        // still comes straight from a flip-flop, free of decode glitches.
        state_next.first_fam   = state_next.family[`DOFC_FIRST_FAM_BIT];
        state_next.second_fam  = state_next.family[`DOFC_SECOND_FAM_BIT];
        state_next.first_code  = state_next.freq[`DOFC_FIRST_CODE_LO +: 2];
        state_next.second_code = state_next.freq[`DOFC_SECOND_CODE_LO +: 2];
        state_next.first_khz   = spot_khz(state_next.first_fam,
                                          state_next.first_code);
        state_next.second_khz  = spot_khz(state_next.second_fam,
                                          state_next.second_code);
        state_next.diff_mode   = diff_decode(state_next.diff[`DOFC_DIFF_LO +: 2]);
    end

    // =================================================================
    // State register
    // =================================================================

    // A low clock enable freezes everything, bus handshakes included, so a
    // master must not expect progress while it is held low.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= RST_STATE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // =================================================================
    // Outputs
    // =================================================================

    assign s_axi_awready            = state_reg.awready;
    assign s_axi_wready             = state_reg.wready;
    assign s_axi_bvalid             = state_reg.bvalid;
    assign s_axi_bresp              = state_reg.bresp;
    assign s_axi_arready            = state_reg.arready;
    assign s_axi_rvalid             = state_reg.rvalid;
    assign s_axi_rresp              = state_reg.rresp;
    assign s_axi_rdata              = state_reg.rdata;
    assign first_output_family_sel  = state_reg.first_fam;
    assign second_output_family_sel = state_reg.second_fam;
    assign first_output_freq_code   = state_reg.first_code;
    assign second_output_freq_code  = state_reg.second_code;
    assign first_aux_clock_out_khz  = state_reg.first_khz;
    assign second_aux_clock_out_khz = state_reg.second_khz;
    assign diff_driver_mode         = state_reg.diff_mode;

endmodule // dofc_top

// File: hdl/dofc_map.svh
`ifndef DOFC_MAP_SVH
`define DOFC_MAP_SVH

// =====================================================================
// Register indices; the byte address on the bus is four times the index.
// =====================================================================
`define DOFC_IDX_FAMILY     10'h038
`define DOFC_IDX_FREQ       10'h039
`define DOFC_IDX_DIFF       10'h03a

// =====================================================================
// Reset values and writable-bit masks.
// =====================================================================
`define DOFC_RST_FAMILY     8'h14
`define DOFC_RST_FREQ       8'h08
`define DOFC_RST_DIFF       8'hc2
`define DOFC_WMASK_FAMILY   8'h60
`define DOFC_WMASK_FREQ     8'hf0
`define DOFC_WMASK_DIFF     8'h03

// =====================================================================
// Field positions.
// =====================================================================
`define DOFC_SECOND_FAM_BIT 6
`define DOFC_FIRST_FAM_BIT  5
`define DOFC_SECOND_CODE_LO 6
`define DOFC_FIRST_CODE_LO  4
`define DOFC_DIFF_LO        0

// =====================================================================
// Spot frequencies in kHz, SONET family then SDH family.
// =====================================================================
`define DOFC_KHZ_SONET_0    15'h0608
`define DOFC_KHZ_SONET_1    15'h0c10
`define DOFC_KHZ_SONET_2    15'h1820
`define DOFC_KHZ_SONET_3    15'h3041
`define DOFC_KHZ_SDH_0      15'h0800
`define DOFC_KHZ_SDH_1      15'h1000
`define DOFC_KHZ_SDH_2      15'h2000
`define DOFC_KHZ_SDH_3      15'h4000

// =====================================================================
// Bus answers.
// =====================================================================
`define DOFC_RESP_OKAY      2'h0
`define DOFC_RESP_SLVERR    2'h2

`endif

// File: hdl/dofc_pkg.sv
package dofc_pkg;

    typedef enum logic [1:0] {
        DOFC_DIFF_OFF,
        DOFC_DIFF_PECL,
        DOFC_DIFF_LVDS
    } dofc_diff_mode_t;

    typedef struct packed {
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [31:0]     rdata;
        logic            aw_got;
        logic            w_got;
        logic [11:0]     awaddr;
        logic [7:0]      wdata;
        logic            wlane0;
        logic [7:0]      family;
        logic [7:0]      freq;
        logic [7:0]      diff;
        logic            first_fam;
        logic            second_fam;
        logic [1:0]      first_code;
        logic [1:0]      second_code;
        logic [14:0]     first_khz;
        logic [14:0]     second_khz;
        dofc_diff_mode_t diff_mode;
    } dofc_state_t;

endpackage

// File: test/dofc_top_checker.sv
`timescale 1ns/1ps
`include "dofc_map.svh"

module dofc_top_checker (
    input logic                      ref_clk,
    input logic                      resetn,
    input logic [11:0]               s_axi_awaddr,
    input logic                      s_axi_awvalid,
    input logic                      s_axi_awready,
    input logic [31:0]               s_axi_wdata,
    input logic [3:0]                s_axi_wstrb,
    input logic                      s_axi_wvalid,
    input logic                      s_axi_wready,
    input logic [1:0]                s_axi_bresp,
    input logic                      s_axi_bvalid,
    input logic [11:0]               s_axi_araddr,
    input logic                      s_axi_arvalid,
    input logic                      s_axi_arready,
    input logic [31:0]               s_axi_rdata,
    input logic                      s_axi_rvalid,
    input logic                      first_output_family_sel,
    input logic                      second_output_family_sel,
    input logic [1:0]                first_output_freq_code,
    input logic [1:0]                second_output_freq_code,
    input logic [14:0]               first_aux_clock_out_khz,
    input logic [14:0]               second_aux_clock_out_khz,
    input dofc_pkg::dofc_diff_mode_t diff_driver_mode
);
    // ==========================================================
    // Helpers. Index is {family bit, code}; family 0 is SDH.
    // ==========================================================
    localparam logic [14:0] KHZ [8] = '{`DOFC_KHZ_SDH_0, `DOFC_KHZ_SDH_1, `DOFC_KHZ_SDH_2,
        `DOFC_KHZ_SDH_3, `DOFC_KHZ_SONET_0, `DOFC_KHZ_SONET_1, `DOFC_KHZ_SONET_2,
        `DOFC_KHZ_SONET_3};
    localparam dofc_pkg::dofc_diff_mode_t DM [4] = '{dofc_pkg::DOFC_DIFF_OFF,
        dofc_pkg::DOFC_DIFF_PECL, dofc_pkg::DOFC_DIFF_LVDS, dofc_pkg::DOFC_DIFF_OFF};
    logic wr_hs;
    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ==========================================================
    // Properties.
    // ==========================================================
    property p_first_khz;
        first_aux_clock_out_khz == KHZ[{first_output_family_sel, first_output_freq_code}];
    endproperty
    a_first_khz: assert property (p_first_khz)
        else $error("first output frequency disagrees with its selection");
    property p_second_khz;
        second_aux_clock_out_khz == KHZ[{second_output_family_sel, second_output_freq_code}];
    endproperty
    a_second_khz: assert property (p_second_khz)
        else $error("second output frequency disagrees with its selection");
    property p_fam_value;
        wr_hs && s_axi_awaddr == 12'h0e0 && s_axi_wstrb[0]
            |=> {second_output_family_sel, first_output_family_sel} == $past(s_axi_wdata[6:5]);
    endproperty
    a_fam_value: assert property (p_fam_value)
        else $error("family selects do not follow the write");
    property p_code_value;
        wr_hs && s_axi_awaddr == 12'h0e4 && s_axi_wstrb[0]
            |=> {second_output_freq_code, first_output_freq_code} == $past(s_axi_wdata[7:4]);
    endproperty
    a_code_value: assert property (p_code_value)
        else $error("frequency codes do not follow the write");
    property p_diff_value;
        wr_hs && s_axi_awaddr == 12'h0e8 && s_axi_wstrb[0]
            |=> diff_driver_mode == DM[$past(s_axi_wdata[1:0])];
    endproperty
    a_diff_value: assert property (p_diff_value)
        else $error("driver mode does not follow the write");
    property p_diff_commit;
        $changed(diff_driver_mode) || $changed(first_output_family_sel) |-> $rose(s_axi_bvalid);
    endproperty
    a_diff_commit: assert property (p_diff_commit)
        else $error("configuration changed without a write completing");
    property p_bresp;
        wr_hs |=> s_axi_bvalid && s_axi_bresp == (($past(s_axi_awaddr) inside
            {12'h0e0, 12'h0e4, 12'h0e8}) ? `DOFC_RESP_OKAY : `DOFC_RESP_SLVERR);
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response wrong or late");
    property p_read_fixed;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0e0
            |=> s_axi_rvalid && (s_axi_rdata & 32'hffffff9f) == 32'h00000014;
    endproperty
    a_read_fixed: assert property (p_read_fixed)
        else $error("unused family bits read wrong");
endmodule // dofc_top_checker

bind dofc_top dofc_top_checker u_checker (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .first_output_family_sel, .second_output_family_sel, .first_output_freq_code,
    .second_output_freq_code, .first_aux_clock_out_khz, .second_aux_clock_out_khz,
    .diff_driver_mode);

// File: test/dofc_top_tb.sv
`timescale 1ns/1ps
`include "dofc_map.svh"

module dofc_top_tb;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        clk_en = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, d;
    logic        first_output_family_sel, second_output_family_sel;
    logic [1:0]  first_output_freq_code, second_output_freq_code, r;
    logic [14:0] first_aux_clock_out_khz, second_aux_clock_out_khz;
    dofc_pkg::dofc_diff_mode_t diff_driver_mode;
    int          num_errors = 0;
    int          samples_checked = 0;
    localparam logic [14:0] KHZ [8] = '{`DOFC_KHZ_SDH_0, `DOFC_KHZ_SDH_1, `DOFC_KHZ_SDH_2,
        `DOFC_KHZ_SDH_3, `DOFC_KHZ_SONET_0, `DOFC_KHZ_SONET_1, `DOFC_KHZ_SONET_2,
        `DOFC_KHZ_SONET_3};
    localparam dofc_pkg::dofc_diff_mode_t DM [4] = '{dofc_pkg::DOFC_DIFF_OFF,
        dofc_pkg::DOFC_DIFF_PECL, dofc_pkg::DOFC_DIFF_LVDS, dofc_pkg::DOFC_DIFF_OFF};

    dofc_top uut (.ref_clk, .resetn, .clk_en, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .first_output_family_sel, .second_output_family_sel,
        .first_output_freq_code, .second_output_freq_code, .first_aux_clock_out_khz,
        .second_aux_clock_out_khz, .diff_driver_mode);

    // ==========================================================
    // Bus tasks. Ready is sampled mid-cycle, where registered outputs are
    // settled, and acted on at the following rising edge.
    // ==========================================================
    task automatic report_and_stop();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [7:0] v, input logic [3:0] st);
        logic aw, w, b;
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge ref_clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge ref_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 40) begin
            num_errors++;
            report_and_stop();
        end
        @(posedge ref_clk);
    endtask

    task automatic axi_read(input logic [11:0] a);
        logic ar, rv;
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge ref_clk);
            ar = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge ref_clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (rv) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 40) begin
            num_errors++;
            report_and_stop();
        end
        @(posedge ref_clk);
    endtask

    // ==========================================================
    // Sequence.
    // ==========================================================
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        axi_read(12'h0e0);
        check("family reset", d, 32'h00000014);
        axi_read(12'h0e4);
        check("freq reset", d, 32'h00000008);
        axi_read(12'h0e8);
        check("diff reset", d, 32'h000000c2);
        check("diff mode reset", {30'h0, diff_driver_mode}, {30'h0, DM[2]});
        check("first khz reset", {17'h0, first_aux_clock_out_khz}, {17'h0, KHZ[0]});
        for (int i = 0; i < 64; i++) begin
            axi_write(12'h0e0, {1'b1, i[5:4], 5'h0b}, 4'h1);
            check("family resp", {30'h0, r}, {30'h0, `DOFC_RESP_OKAY});
            axi_write(12'h0e4, {i[3:0], 4'h7}, 4'h1);
            axi_read(12'h0e0);
            check("family read", d, {24'h0, 1'b0, i[5:4], 5'h14});
            axi_read(12'h0e4);
            check("freq read", d, {24'h0, i[3:0], 4'h8});
            check("first sel", {31'h0, first_output_family_sel}, {31'h0, i[4]});
            check("second sel", {31'h0, second_output_family_sel}, {31'h0, i[5]});
            check("first code", {30'h0, first_output_freq_code}, {30'h0, i[1:0]});
            check("second code", {30'h0, second_output_freq_code}, {30'h0, i[3:2]});
            check("first khz", {17'h0, first_aux_clock_out_khz},
                  {17'h0, KHZ[{i[4], i[1:0]}]});
            check("second khz", {17'h0, second_aux_clock_out_khz},
                  {17'h0, KHZ[{i[5], i[3:2]}]});
        end
        for (int m = 0; m < 4; m++) begin
            axi_write(12'h0e8, {6'h2a, m[1:0]}, 4'h1);
            axi_read(12'h0e8);
            check("diff read", d, {24'h0, 6'h30, m[1:0]});
            check("diff mode", {30'h0, diff_driver_mode}, {30'h0, DM[m]});
        end
        // A request held while the clock enable is low must wait, then complete.
        clk_en <= 1'b0;
        s_axi_araddr <= 12'h0e8;
        s_axi_arvalid <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check("frozen rvalid", {31'h0, s_axi_rvalid}, 32'h0);
        check("frozen arready", {31'h0, s_axi_arready}, 32'h1);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        axi_read(12'h0e8);
        check("thawed read", d, 32'h000000c3);
        axi_write(12'h0e0, 8'h00, 4'h0);
        axi_read(12'h0e0);
        check("strobe off", d, 32'h00000074);
        axi_write(12'h0ec, 8'hff, 4'h1);
        check("unmapped wresp", {30'h0, r}, {30'h0, `DOFC_RESP_SLVERR});
        axi_read(12'h0ec);
        check("unmapped rresp", {30'h0, r}, {30'h0, `DOFC_RESP_SLVERR});
        check("unmapped rdata", d, 32'h00000000);
        report_and_stop();
    end
endmodule // dofc_top_tb
